// file: verilog/pfd_pkg.sv
// constants and state types for the phase-frequency detector
package pfd_pkg;

  // width of the phase-difference counter in bits; it counts sys_clk cycles
  localparam int unsigned CNT_W = 16;

  typedef logic [CNT_W-1:0] pfd_cnt_t;

  // counter saturates here instead of wrapping
  localparam pfd_cnt_t CNT_MAX = {CNT_W{1'b1}};
  localparam pfd_cnt_t CNT_ONE = 16'h0001;
  localparam pfd_cnt_t CNT_RST = 16'h0000;

  // idle: no pulse, lead: up pulse running, lag: down pulse running
  typedef enum logic [1:0] {
    PFD_IDLE,
    PFD_LEAD,
    PFD_LAG
  } pfd_mode_t;

  // complete state of the detector
  typedef struct packed {
    pfd_mode_t mode;
    logic      ref_q;
    logic      fb_q;
    pfd_cnt_t  cnt;
    pfd_cnt_t  width;
    logic      ref_led;
    logic      done;
  } pfd_state_t;

  // value after reset: idle, inputs taken as low, nothing measured
  localparam pfd_state_t PFD_STATE_RST = '{
    mode:    PFD_IDLE,
    ref_q:   1'b0,
    fb_q:    1'b0,
    cnt:     CNT_RST,
    width:   CNT_RST,
    ref_led: 1'b0,
    done:    1'b0
  };

endpackage

// file: verilog/pfd_top.sv
// phase-frequency detector: lead/lag pulses from rising edges of two inputs
//
// Behaviour
// - Only rising edges of the reference and feedback inputs count, and the time between them is measured.
// - When the reference leads, up is high for the phase difference while down stays low.
// - When the feedback leads, down is high for the phase difference while up stays low.
// - A running pulse ignores further edges of its own input, so the range spans plus or minus two pi.
// - Which output pulses depends on edge history and start-up state, and either polarity is valid.
`timescale 1ns/10ps
`default_nettype none

module pfd_top (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 ref_in,
  input  wire logic                 fb_in,
  output logic                      up,
  output logic                      up_n,
  output logic                      dn,
  output logic                      dn_n,
  output pfd_pkg::pfd_cnt_t         phase_width,
  output logic                      ref_leads,
  output logic                      width_valid
);

  pfd_pkg::pfd_state_t state_reg;
  pfd_pkg::pfd_state_t state_next;
  logic                ref_rise;
  logic                fb_rise;

  // rising edge from the current sample and the previous one
  function automatic logic rise_of(input logic now, input logic prev);
    rise_of = now & ~prev;
  endfunction

  // saturating increment of the phase counter
  function automatic pfd_pkg::pfd_cnt_t sat_inc(input pfd_pkg::pfd_cnt_t v);
    if (v == pfd_pkg::CNT_MAX) begin
      sat_inc = v;
    end else begin
      sat_inc = v + pfd_pkg::CNT_ONE;
    end
  endfunction

  // edge detect on the synchronous inputs
  // the previous-sample flops clear on reset, so a pin already high at
  // release reads as a rising edge in the first cycle; drivers hold the
  // pins low through reset to avoid a false start
  assign ref_rise = rise_of(ref_in, state_reg.ref_q);
  assign fb_rise  = rise_of(fb_in, state_reg.fb_q);

  // next-state logic
  always_comb begin
    state_next       = state_reg;
    state_next.ref_q = ref_in;
    state_next.fb_q  = fb_in;
    state_next.done  = 1'b0;
    case (state_reg.mode)
      pfd_pkg::PFD_IDLE: begin
        if (ref_rise && fb_rise) begin
          // coincident edges: zero phase error, no pulse at all
          state_next.width = pfd_pkg::CNT_RST;
          state_next.done  = 1'b1;
        end else if (ref_rise) begin
          state_next.mode = pfd_pkg::PFD_LEAD;
          state_next.cnt  = pfd_pkg::CNT_ONE;
        end else if (fb_rise) begin
          state_next.mode = pfd_pkg::PFD_LAG;
          state_next.cnt  = pfd_pkg::CNT_ONE;
        end
      end
      pfd_pkg::PFD_LEAD: begin
        if (fb_rise) begin
          // down would join up: clear both and report the width
          state_next.mode    = pfd_pkg::PFD_IDLE;
          state_next.width   = state_reg.cnt;
          state_next.ref_led = 1'b1;
          state_next.done    = 1'b1;
        end else begin
          state_next.cnt = sat_inc(state_reg.cnt);
        end
      end
      pfd_pkg::PFD_LAG: begin
        if (ref_rise) begin
          state_next.mode    = pfd_pkg::PFD_IDLE;
          state_next.width   = state_reg.cnt;
          state_next.ref_led = 1'b0;
          state_next.done    = 1'b1;
        end else begin
          state_next.cnt = sat_inc(state_reg.cnt);
        end
      end
      default: begin
        state_next.mode = pfd_pkg::PFD_IDLE;
      end
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= pfd_pkg::PFD_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs decoded from the state register
  assign up          = (state_reg.mode == pfd_pkg::PFD_LEAD);
  assign dn          = (state_reg.mode == pfd_pkg::PFD_LAG);
  assign up_n        = ~up;
  assign dn_n        = ~dn;
  assign phase_width = state_reg.width;
  assign ref_leads   = state_reg.ref_led;
  assign width_valid = state_reg.done;

  // step sequences for the checks below
  sequence s_ref_start;
    !up && !dn && ref_rise && !fb_rise;
  endsequence

  sequence s_fb_start;
    !up && !dn && fb_rise && !ref_rise;
  endsequence

  sequence s_lead_end;
    up && fb_rise;
  endsequence

  sequence s_lag_end;
    dn && ref_rise;
  endsequence

  sequence s_both_start;
    !up && !dn && ref_rise && fb_rise;
  endsequence

  // a reference edge from idle starts an up pulse with down low
  a_up_starts: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_ref_start |=> up && !dn && (phase_width == $past(phase_width)))
    else $error("up pulse did not start on reference edge");

  // a feedback edge from idle starts a down pulse with up low
  a_dn_starts: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_fb_start |=> dn && !up)
    else $error("down pulse did not start on feedback edge");

  // the closing edge ends the pulse and reports its measured width
  a_lead_width: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_lead_end |=> !up && !dn && width_valid && ref_leads
                   && (phase_width == $past(state_reg.cnt)))
    else $error("lead pulse not closed or width wrong");

  a_lag_width: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_lag_end |=> !up && !dn && width_valid && !ref_leads
                  && (phase_width == $past(state_reg.cnt)))
    else $error("lag pulse not closed or width wrong");

  // up and down are never high together and complements track them
  a_never_both: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(up && dn) && (up_n == !up) && (dn_n == !dn))
    else $error("up and down both active or complements wrong");

  // repeated edges of the leading input keep the pulse running
  a_lead_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    up && !fb_rise |=> up && (state_reg.cnt >= $past(state_reg.cnt)))
    else $error("up pulse ended without a feedback edge");

  // without a rising edge an idle detector stays idle
  a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !up && !dn && !ref_rise && !fb_rise |=> !up && !dn && !width_valid)
    else $error("pulse started without a rising edge");

  // coincident edges from idle report zero width with no pulse
  a_both_edges: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_both_start |=> !up && !dn && width_valid && (phase_width == pfd_pkg::CNT_RST)
                     && (ref_leads == $past(ref_leads)))
    else $error("coincident edges not reported as zero width");

  // repeated edges of the leading input keep the down pulse running
  a_lag_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    dn && !ref_rise |=> dn && (state_reg.cnt >= $past(state_reg.cnt)))
    else $error("down pulse ended without a reference edge");

  // a second reference edge during an up pulse is ignored
  a_lead_refused: assert property (@(posedge sys_clk) disable iff (!reset_n)
    up && ref_rise && !fb_rise |=> up && !dn && !width_valid)
    else $error("reference edge disturbed a running up pulse");

  // a second feedback edge during a down pulse is ignored
  a_lag_refused: assert property (@(posedge sys_clk) disable iff (!reset_n)
    dn && fb_rise && !ref_rise |=> dn && !up && !width_valid)
    else $error("feedback edge disturbed a running down pulse");

  // a new pulse starts its count at one cycle
  a_cnt_loads: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !up && !dn && (ref_rise ^ fb_rise) |=> (state_reg.cnt == pfd_pkg::CNT_ONE))
    else $error("phase counter not loaded at pulse start");

  // the completion strobe lasts one cycle and finds the detector idle
  a_valid_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
    width_valid |=> !width_valid)
    else $error("width valid held for more than one cycle");

  a_valid_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    width_valid |-> !up && !dn)
    else $error("pulse still active at completion");

  // the measurement only changes together with the completion strobe
  a_width_held: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !width_valid && $past(reset_n) |-> $stable(phase_width)
                                       && $stable(ref_leads))
    else $error("measurement changed without completion");

  // reset returns the detector to idle with nothing measured
  a_reset_idle: assert property (@(posedge sys_clk)
    !reset_n |=> !up && !dn && !width_valid && !ref_leads
                 && (phase_width == pfd_pkg::CNT_RST))
    else $error("detector not idle after reset");

endmodule

`default_nettype wire

// file: testbench/pfd_osc.sv
// partner model: reference and loop oscillator edge pairs
`timescale 1ns/10ps
`default_nettype none
module pfd_osc (
  input  wire logic sys_clk,
  output var  logic ref_in,
  output var  logic fb_in
);
  initial begin
    ref_in = 1'b0;
    fb_in  = 1'b0;
  end
  // leader rises, pulses again mid-run when long, trailer rises gap cycles later
  task automatic pair(input logic rl, input int gap);
    int i;
    @(posedge sys_clk) #1;
    if (gap == 0) {ref_in, fb_in} = 2'b11;
    else if (rl) ref_in = 1'b1;
    else fb_in = 1'b1;
    for (i = 1; i <= gap; i++) begin
      @(posedge sys_clk) #1;
      if (rl) ref_in = (i == 2 && gap > 3);
      else fb_in = (i == 2 && gap > 3);
      if (i == gap && rl) fb_in = 1'b1;
      else if (i == gap) ref_in = 1'b1;
    end
    @(posedge sys_clk) #1;
    {ref_in, fb_in} = 2'b00;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// file: testbench/phase_frequency_detector_tb.sv
// self-checking bench for the phase-frequency detector
`timescale 1ns/10ps
`default_nettype none
module phase_frequency_detector_tb;
  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              ref_in, fb_in, up, up_n, dn, dn_n, ref_leads, width_valid;
  pfd_pkg::pfd_cnt_t phase_width;
  int                failures = 0;
  int                comparisons = 0;
  int                seed = 32'hfe61a81e;
  int                up_cnt = 0;
  int                dn_cnt = 0;
  int                g;
  logic              last_lead = 1'b0;
  logic [16:0]       exp_q[$];
  logic [16:0]       e;

  always #4 sys_clk = ~sys_clk;

  pfd_top i_pfd_top (.sys_clk(sys_clk), .reset_n(reset_n), .ref_in(ref_in), .fb_in(fb_in),
    .up(up), .up_n(up_n), .dn(dn), .dn_n(dn_n), .phase_width(phase_width),
    .ref_leads(ref_leads), .width_valid(width_valid));
  pfd_osc i_pfd_osc (.sys_clk(sys_clk), .ref_in(ref_in), .fb_in(fb_in));

  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // print counts and verdict, then stop
  task final_report;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // monitor: pulse lengths, complements and each completed measurement
  always @(negedge sys_clk) begin
    if (reset_n) begin
      chk({up_n, dn_n}, {~up, ~dn});
      chk(up & dn, 0);
      up_cnt += up;
      dn_cnt += dn;
      if (width_valid) begin
        e = exp_q.pop_front();
        chk({ref_leads, phase_width}, e);
        chk(e[16] ? up_cnt : dn_cnt, e[15:0]);
        chk(e[16] ? dn_cnt : up_cnt, 0);
        up_cnt = 0;
        dn_cnt = 0;
      end
    end
  end

  // reset, then both directions, two conditioning pairs first, coincident last
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    chk({up, dn, up_n, dn_n, ref_leads, width_valid, phase_width}, 22'h0c0000);
    $display("test reset done");
    for (int d = 1; d >= 0; d--) begin
      // first two pairs of each direction give the leader two pulses before the trailer
      for (int k = 0; k < 8; k++) begin
        g = (k == 7) ? 0 : (k < 2) ? 4 : 1 + ($random(seed) & 15);
        if (g != 0) last_lead = d[0];
        exp_q.push_back({last_lead, g[15:0]});
        i_pfd_osc.pair(d[0], g);
      end
      $display("test direction %0d done", d);
    end
    repeat (4) @(posedge sys_clk);
    chk(exp_q.size(), 0);
    final_report;
  end

  // watchdog
  initial begin
    #40000;
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
